// file: rtl/csw_cfg.svh
// offsets, fields, reset values and timing counts of the cyclic sense/wake timer
// assumes a 20 MHz clock; included by the timer module and its bench
//
// Summary of operation
// - cyclic sensing pulses the high-side output each period for the set on-time
// - level change at on-time wakes: interrupt in normal/stop, supply back on from sleep
// - writing a valid on-time starts the timer in any mode except restart
// - on-time longer than period sets the command error flag
// - start with pin in cyclic high-side mode begins a learning cycle
// - first sample is only the reference; later differing samples cause a wake
// - 16 us filter after each on-time; level must differ and stay stable
// - every cyclic sense wake sets the wake input event flag
// - in normal/stop with cyclic sensing, level status takes only sampled levels
// - in stop, flag and level update only with the shortest on-time code
// - wake events repeat even when the event flag is already set
// - fail-safe turns the high-side output off and returns to static sensing
// - in normal, stop or sleep, overcurrent or second thermal shutdown turns the high-side output off
// - timer survives output faults; cleared in restart mode or by a timer register write
// - sleep command with uncleared wake flags wakes at once and asserts reset
// - overcurrent in sleep with cyclic sensing as only source leaves sleep
// - cyclic wake interrupts in normal/stop, wakes through restart from sleep
// - cyclic wake interrupt at each on-time start except the first
// - sixteen periods 10 ms to 1000 s, five on-times, or off high/low
// - static sensing watches the wake input continuously when enabled
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH

`define CSW_ADDR_TIMER 4'h0
`define CSW_ADDR_WKSRC 4'h1
`define CSW_ADDR_GPCFG 4'h2
`define CSW_ADDR_STAT1 4'h3
`define CSW_ADDR_STAT2 4'h4
`define CSW_ADDR_LEVEL 4'h5
`define CSW_ADDR_ERROR 4'h6

`define CSW_PER_F 3:0
`define CSW_ON_F 6:4
`define CSW_GP_HS_CS 3'h3
`define CSW_ON_OFF_LO 3'h0
`define CSW_ON_MIN 3'h1
`define CSW_ON_OFF_HI 3'h6
`define CSW_ON_OFF_LO2 3'h7
`define CSW_RST_PER 4'h0
`define CSW_RST_ON 3'h0
`define CSW_RST_GP 3'h0

`define CSW_CLK_NS 50
`define CSW_TICK_NS 100000
`define CSW_TICK_CYC (`CSW_TICK_NS / `CSW_CLK_NS)
`define CSW_FILT_NS 16000
`define CSW_FILT_CYC ((`CSW_FILT_NS + `CSW_CLK_NS - 1) / `CSW_CLK_NS)
`define CSW_INT_NS 5000
`define CSW_INT_CYC ((`CSW_INT_NS + `CSW_CLK_NS - 1) / `CSW_CLK_NS)
`define CSW_TICK_US 100
`define CSW_ON1_US 100
`define CSW_ON2_US 300
`define CSW_ON3_US 1000
`define CSW_ON4_US 10000
`define CSW_ON5_US 20000
`define CSW_TICKS_PER_MS 10

`endif

// file: rtl/csw_pkg.sv
// types of the cyclic sense/wake timer
// assumes the device mode comes from the surrounding mode controller
package csw_pkg;
    typedef enum logic [2:0] {CSW_NORMAL, CSW_STOP, CSW_SLEEP, CSW_RESTART, CSW_FAILSAFE} csw_mode_t;
    typedef enum logic {CSW_IDLE, CSW_RUN} csw_state_t;
endpackage : csw_pkg

// file: rtl/csw_timer.sv
// cyclic sense and cyclic wake timer with its register port
// assumes synchronous inputs and a mode controller that acts on wake_req
`timescale 1ns/1ns
`include "csw_cfg.svh"
`default_nettype none
module csw_timer #(
    parameter int unsigned TICK_CYC = `CSW_TICK_CYC // 0.1 ms time base
) (
    input wire logic clk, // 20 MHz
    input wire logic srst, // sync reset
    input wire logic ce, // clock enable
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    input wire csw_pkg::csw_mode_t mode, // device mode
    input wire logic sleep_cmd, // sleep commanded
    input wire logic wake_sense_input, // wake pin level
    input wire logic hs_overcurrent, // output overcurrent
    input wire logic thermal_shutdown_second, // second thermal level
    output logic high_side_switch, // high-side drive
    output logic interrupt_out_n, // interrupt, low active
    output logic reset_out_n, // reset, low active
    output logic main_supply_rail_en, // main supply enable
    output logic wake_req // pulse: go restart/normal
);
    import csw_pkg::*;

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [3:0] period_r;
    logic [2:0] ontime_r;
    logic [2:0] gp_cfg_r;
    logic wk_in_en_r, tmr_wk_en_r;
    logic wk_flag_r, tmr_flag_r, oc_flag_r, tsd_flag_r;
    logic lvl_r, cmd_err_r, hs_fault_r, woke_r;
    csw_state_t state_r;
    logic [15:0] tick_r;
    logic [23:0] per_cnt_r;
    logic learn_r, ref_r, samp_r, stable_r, filt_on_r, in_d_r;
    logic [8:0] filt_r;
    logic [7:0] int_cnt_r;

    // ----------------------------------------
    // timing tables
    // ----------------------------------------
    function automatic logic [23:0] per_ticks(input logic [3:0] c);
        logic [23:0] ms;
        ms = 24'h0;
        case (c)
            4'h0: ms = 24'd10;
            4'h1: ms = 24'd20;
            4'h2: ms = 24'd50;
            4'h3: ms = 24'd100;
            4'h4: ms = 24'd200;
            4'h5: ms = 24'd500;
            4'h6: ms = 24'd1000;
            4'h7: ms = 24'd2000;
            4'h8: ms = 24'd5000;
            4'h9: ms = 24'd10000;
            4'hA: ms = 24'd20000;
            4'hB: ms = 24'd50000;
            4'hC: ms = 24'd100000;
            4'hD: ms = 24'd200000;
            4'hE: ms = 24'd500000;
            default: ms = 24'd1000000;
        endcase
        return 24'(ms * `CSW_TICKS_PER_MS);
    endfunction : per_ticks

    function automatic logic [23:0] on_ticks(input logic [2:0] c);
        int unsigned us;
        us = 0;
        case (c)
            3'h1: us = `CSW_ON1_US;
            3'h2: us = `CSW_ON2_US;
            3'h3: us = `CSW_ON3_US;
            3'h4: us = `CSW_ON4_US;
            3'h5: us = `CSW_ON5_US;
            default: us = 0;
        endcase
        return 24'(us / `CSW_TICK_US);
    endfunction : on_ticks

    // ----------------------------------------
    // decode and events
    // ----------------------------------------
    logic tmr_wr, on_valid, run, tick, on_begin, on_end, in_on, cs_mode, cs_run;
    logic filt_done, sample_ok, upd_ok, cs_evt, st_evt, tmr_evt, wk_evt;
    logic fault, low_pwr_ok, imm_wake, oc_sleep, wake_nxt, irq_load;
    logic [23:0] per_max, on_max;

    assign tmr_wr = wr && addr == `CSW_ADDR_TIMER;
    assign on_valid = wdata[`CSW_ON_F] != `CSW_ON_OFF_LO && wdata[`CSW_ON_F] != `CSW_ON_OFF_HI
        && wdata[`CSW_ON_F] != `CSW_ON_OFF_LO2;
    assign per_max = per_ticks(period_r);
    assign on_max = on_ticks(ontime_r);
    assign run = state_r == CSW_RUN;
    assign tick = run && tick_r == 16'(TICK_CYC - 1);
    assign on_begin = tick && per_cnt_r == per_max - 24'h1;
    assign on_end = tick && per_cnt_r == on_max - 24'h1;
    assign in_on = run && per_cnt_r < on_max;
    // fail-safe falls back to static sensing
    assign cs_mode = gp_cfg_r == `CSW_GP_HS_CS && mode != CSW_FAILSAFE;
    assign cs_run = cs_mode && run;
    assign filt_done = filt_on_r && filt_r == 9'h0;
    assign sample_ok = filt_done && stable_r && wake_sense_input == samp_r;
    assign upd_ok = mode != CSW_STOP || ontime_r == `CSW_ON_MIN;
    // no flag gating: a set flag does not suppress a new event
    assign cs_evt = sample_ok && wk_in_en_r && !learn_r && samp_r != ref_r && upd_ok;
    assign st_evt = wk_in_en_r && !cs_run && mode != CSW_RESTART
        && in_d_r != wake_sense_input;
    // timer start writes per_cnt to zero, so the first on-time raises nothing
    assign tmr_evt = on_begin && tmr_wk_en_r;
    assign wk_evt = cs_evt || st_evt || tmr_evt;
    assign low_pwr_ok = mode == CSW_NORMAL || mode == CSW_STOP || mode == CSW_SLEEP;
    assign fault = low_pwr_ok && (hs_overcurrent || thermal_shutdown_second);
    assign imm_wake = sleep_cmd && (wk_flag_r || tmr_flag_r || oc_flag_r || tsd_flag_r);
    assign oc_sleep = mode == CSW_SLEEP && hs_overcurrent && cs_mode && wk_in_en_r
        && !tmr_wk_en_r && !hs_fault_r;
    assign wake_nxt = (mode == CSW_SLEEP && wk_evt) || imm_wake || oc_sleep;
    assign irq_load = (mode == CSW_NORMAL || mode == CSW_STOP) && wk_evt;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            period_r <= `CSW_RST_PER;
            ontime_r <= `CSW_RST_ON;
            gp_cfg_r <= `CSW_RST_GP;
            wk_in_en_r <= 1'b0;
            tmr_wk_en_r <= 1'b0;
        end
        else if (ce && wr)
        begin
            if (addr == `CSW_ADDR_TIMER)
            begin
                period_r <= wdata[`CSW_PER_F];
                ontime_r <= wdata[`CSW_ON_F];
            end
            if (addr == `CSW_ADDR_WKSRC)
            begin
                wk_in_en_r <= wdata[0];
                tmr_wk_en_r <= wdata[1];
            end
            if (addr == `CSW_ADDR_GPCFG)
                gp_cfg_r <= wdata[2:0];
        end
    end

    // ----------------------------------------
    // timer
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= CSW_IDLE;
            tick_r <= 16'h0;
            per_cnt_r <= 24'h0;
        end
        else if (ce)
        begin
            if (mode == CSW_RESTART)
            begin
                state_r <= CSW_IDLE;
                tick_r <= 16'h0;
                per_cnt_r <= 24'h0;
            end
            else if (tmr_wr)
            begin
                state_r <= on_valid ? CSW_RUN : CSW_IDLE;
                tick_r <= 16'h0;
                per_cnt_r <= 24'h0;
            end
            else
            begin
                case (state_r)
                    CSW_RUN:
                    begin
                        tick_r <= tick ? 16'h0 : tick_r + 16'h1;
                        if (tick)
                            per_cnt_r <= on_begin ? 24'h0 : per_cnt_r + 24'h1;
                    end
                    default:
                    begin
                        tick_r <= 16'h0;
                        per_cnt_r <= 24'h0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // high-side drive and faults
    // ----------------------------------------
    // the fault latch does not touch the timer; a pin rewrite re-arms
    always_ff @(posedge clk)
    begin
        if (srst)
            hs_fault_r <= 1'b0;
        else if (ce)
        begin
            if (fault)
                hs_fault_r <= 1'b1;
            else if (wr && addr == `CSW_ADDR_GPCFG)
                hs_fault_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            high_side_switch <= 1'b0;
        else if (ce)
            high_side_switch <= cs_mode && !hs_fault_r && !fault
                && (in_on || ontime_r == `CSW_ON_OFF_HI);
    end

    // ----------------------------------------
    // sampling and filter
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            filt_on_r <= 1'b0;
            filt_r <= 9'h0;
            samp_r <= 1'b0;
            stable_r <= 1'b0;
        end
        else if (ce)
        begin
            if (mode == CSW_RESTART || !cs_run)
                filt_on_r <= 1'b0;
            else if (on_end)
            begin
                filt_on_r <= 1'b1;
                filt_r <= 9'(`CSW_FILT_CYC - 1);
                samp_r <= wake_sense_input;
                stable_r <= 1'b1;
            end
            else if (filt_on_r)
            begin
                if (wake_sense_input != samp_r)
                    stable_r <= 1'b0;
                if (filt_done)
                    filt_on_r <= 1'b0;
                else
                    filt_r <= filt_r - 9'h1;
            end
        end
    end

    // reference only moves on a clean sample
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            learn_r <= 1'b0;
            ref_r <= 1'b0;
        end
        else if (ce)
        begin
            if (tmr_wr && on_valid)
                learn_r <= gp_cfg_r == `CSW_GP_HS_CS;
            else if (sample_ok)
            begin
                learn_r <= 1'b0;
                ref_r <= samp_r;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            in_d_r <= wake_sense_input; // no false edge after reset
            lvl_r <= 1'b0;
        end
        else if (ce)
        begin
            in_d_r <= wake_sense_input;
            if (cs_run && (mode == CSW_NORMAL || mode == CSW_STOP))
            begin
                if (sample_ok && upd_ok)
                    lvl_r <= samp_r;
            end
            else
                lvl_r <= wake_sense_input;
        end
    end

    // ----------------------------------------
    // status flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wk_flag_r <= 1'b0;
            tmr_flag_r <= 1'b0;
            oc_flag_r <= 1'b0;
            tsd_flag_r <= 1'b0;
            cmd_err_r <= 1'b0;
        end
        else if (ce)
        begin
            if (cs_evt || st_evt)
                wk_flag_r <= 1'b1;
            else if (wr && addr == `CSW_ADDR_STAT1 && wdata[0])
                wk_flag_r <= 1'b0;
            if (tmr_evt)
                tmr_flag_r <= 1'b1;
            else if (wr && addr == `CSW_ADDR_STAT1 && wdata[1])
                tmr_flag_r <= 1'b0;
            if (fault && hs_overcurrent)
                oc_flag_r <= 1'b1;
            else if (wr && addr == `CSW_ADDR_STAT2 && wdata[0])
                oc_flag_r <= 1'b0;
            if (fault && thermal_shutdown_second)
                tsd_flag_r <= 1'b1;
            else if (wr && addr == `CSW_ADDR_STAT2 && wdata[1])
                tsd_flag_r <= 1'b0;
            if (tmr_wr && on_valid && on_ticks(wdata[`CSW_ON_F]) > per_ticks(wdata[`CSW_PER_F]))
                cmd_err_r <= 1'b1;
            else if (wr && addr == `CSW_ADDR_ERROR && wdata[0])
                cmd_err_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // wake, interrupt and reset outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            int_cnt_r <= 8'h0;
            interrupt_out_n <= 1'b1;
        end
        else if (ce)
        begin
            if (irq_load)
            begin
                int_cnt_r <= 8'(`CSW_INT_CYC - 1);
                interrupt_out_n <= 1'b0;
            end
            else if (int_cnt_r != 8'h0)
                int_cnt_r <= int_cnt_r - 8'h1;
            else
                interrupt_out_n <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wake_req <= 1'b0;
            reset_out_n <= 1'b0;
            main_supply_rail_en <= 1'b1;
            woke_r <= 1'b0;
        end
        else if (ce)
        begin
            wake_req <= wake_nxt;
            reset_out_n <= !(mode == CSW_RESTART || imm_wake);
            // supply stays on after a sleep wake until the mode controller leaves sleep
            woke_r <= wake_nxt || (woke_r && mode == CSW_SLEEP);
            if (wake_nxt)
                main_supply_rail_en <= 1'b1;
            else if (mode == CSW_FAILSAFE || (mode == CSW_SLEEP && !woke_r))
                main_supply_rail_en <= 1'b0;
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata <= 8'h00;
        else if (ce)
        begin
            rdata <= 8'h00;
            if (rd)
            begin
                case (addr)
                    `CSW_ADDR_TIMER: rdata <= {1'b0, ontime_r, period_r};
                    `CSW_ADDR_WKSRC: rdata <= {6'h00, tmr_wk_en_r, wk_in_en_r};
                    `CSW_ADDR_GPCFG: rdata <= {4'h0, hs_fault_r, gp_cfg_r};
                    `CSW_ADDR_STAT1: rdata <= {6'h00, tmr_flag_r, wk_flag_r};
                    `CSW_ADDR_STAT2: rdata <= {6'h00, tsd_flag_r, oc_flag_r};
                    `CSW_ADDR_LEVEL: rdata <= {6'h00, run, lvl_r};
                    `CSW_ADDR_ERROR: rdata <= {7'h00, cmd_err_r};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_start;
        ce && tmr_wr && on_valid && mode != CSW_RESTART |=> run;
    endproperty
    a_start: assert property (p_start) else $error("valid on-time did not start timer");

    property p_learn;
        ce && tmr_wr && on_valid && gp_cfg_r == `CSW_GP_HS_CS |=> learn_r;
    endproperty
    a_learn: assert property (p_learn) else $error("no learning cycle on start");

    property p_err;
        ce && tmr_wr && on_valid && on_ticks(wdata[6:4]) > per_ticks(wdata[3:0]) |=> cmd_err_r;
    endproperty
    a_err: assert property (p_err) else $error("long on-time not flagged");

    property p_fault;
        ce && fault |=> !high_side_switch ##1 (!ce || !high_side_switch);
    endproperty
    a_fault: assert property (p_fault) else $error("output on after fault");

    property p_fs;
        ce && mode == CSW_FAILSAFE |=> !high_side_switch;
    endproperty
    a_fs: assert property (p_fs) else $error("output on in fail-safe");

    property p_restart;
        ce && mode == CSW_RESTART |=> !run && per_cnt_r == 24'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not cleared in restart");

    property p_imm;
        ce && imm_wake |=> !reset_out_n && wake_req;
    endproperty
    a_imm: assert property (p_imm) else $error("sleep with flags did not wake");

    property p_flag;
        ce && cs_evt |=> wk_flag_r;
    endproperty
    a_flag: assert property (p_flag) else $error("cyclic wake left flag clear");

    property p_irq;
        ce && irq_load ##1 ce[*2] |-> !interrupt_out_n ##1 !interrupt_out_n;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt pulse too short");

    property p_stop;
        ce && mode == CSW_STOP && ontime_r != `CSW_ON_MIN |-> !cs_evt;
    endproperty
    a_stop: assert property (p_stop) else $error("stop update with long on-time");

    c_cs_wake: cover property (ce && cs_evt && mode == CSW_NORMAL);
    c_tmr_sleep: cover property (ce && tmr_evt && mode == CSW_SLEEP);
    c_learn: cover property (ce && learn_r && sample_ok);
    c_imm: cover property (ce && imm_wake);
endmodule : csw_timer
`default_nettype wire

// file: sim/csw_wake_sw.sv
// external wake switch to ground, with a pull-up at the wake pin
// assumes the bench opens and closes the switch only between on-times
`timescale 1ns/1ns
`default_nettype none
module csw_wake_sw (
    input wire logic sw_closed, // switch state from the bench
    output logic wake_sense_input // level seen at the wake pin
);
    // the pull-up holds the pin high while the switch is open, so no floating level
    assign wake_sense_input = sw_closed ? 1'b0 : 1'b1;
endmodule : csw_wake_sw
`default_nettype wire

// file: sim/tb.sv
// self-checking bench of the cyclic sense/wake timer
// assumes a wake switch model at the pin and a short tick of 4 clocks
`timescale 1ns/1ns
`default_nettype none
`include "csw_cfg.svh"
module tb;
    import csw_pkg::*;
    // 4-clock tick: 10 ms period is 400 clocks, 1 ms on-time 40 clocks
    localparam int unsigned TICK = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep_cmd = 1'b0;
    logic hs_oc = 1'b0;
    logic sw_closed = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    csw_mode_t mode = CSW_NORMAL;
    logic wsi, hs, int_n, rst_n, rail_en, wake_req;
    logic int_d = 1'b1;
    int error_cnt = 0;
    int num_checks = 0;
    int int_cnt = 0;
    int wk_cnt = 0;
    int rl_cnt = 0;
    int hs_cnt = 0;
    int n0, w0, r0, h0;
    logic tsd = 1'b0;
    // registers other than the level status read back as zero after reset, the unmapped place included
    logic [3:0] n0_list [7] = '{`CSW_ADDR_TIMER, `CSW_ADDR_WKSRC, `CSW_ADDR_GPCFG,
        `CSW_ADDR_STAT1, `CSW_ADDR_STAT2, `CSW_ADDR_ERROR, 4'hF};

    initial forever #25 clk = ~clk;

    csw_timer #(.TICK_CYC(TICK)) u_csw_timer (.clk(clk), .srst(srst), .ce(1'b1),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mode(mode),
        .sleep_cmd(sleep_cmd), .wake_sense_input(wsi), .hs_overcurrent(hs_oc),
        .thermal_shutdown_second(tsd), .high_side_switch(hs), .interrupt_out_n(int_n),
        .reset_out_n(rst_n), .main_supply_rail_en(rail_en), .wake_req(wake_req));
    csw_wake_sw u_csw_wake_sw (.sw_closed(sw_closed), .wake_sense_input(wsi));

    // event counters; interrupt pulses retrigger, so falling edges are counted
    always @(posedge clk)
    begin
        int_d <= int_n;
        if (int_d === 1'b1 && int_n === 1'b0) int_cnt <= int_cnt + 1;
        if (wake_req === 1'b1) wk_cnt <= wk_cnt + 1;
        if (rst_n === 1'b0) rl_cnt <= rl_cnt + 1;
        if (hs === 1'b1) hs_cnt <= hs_cnt + 1;
    end

    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask : rd_chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task restart;
        mode <= CSW_RESTART;
        cyc(4);
        chk({7'h00, rst_n}, 8'h00);
        rd_chk(`CSW_ADDR_LEVEL, 8'h02, 8'h00);
        mode <= CSW_NORMAL;
    endtask : restart
    task give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    initial
    begin
        #1000000;
        error_cnt++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        cyc(2);
        chk({4'h0, hs, int_n, rst_n, rail_en}, 8'h07);
        foreach (n0_list[i]) rd_chk(n0_list[i], 8'hFF, 8'h00);
        $display("test reset done");
        wr_reg(`CSW_ADDR_TIMER, 8'h50);
        rd_chk(`CSW_ADDR_ERROR, 8'h01, 8'h01);
        rd_chk(`CSW_ADDR_LEVEL, 8'h02, 8'h02);
        wr_reg(`CSW_ADDR_TIMER, 8'h10);
        wr_reg(`CSW_ADDR_ERROR, 8'h01);
        rd_chk(`CSW_ADDR_ERROR, 8'h01, 8'h00);
        restart();
        $display("test error done");
        wr_reg(`CSW_ADDR_WKSRC, 8'h02);
        wr_reg(`CSW_ADDR_TIMER, 8'h10);
        n0 = int_cnt;
        cyc(380);
        chk(8'(int_cnt - n0), 8'h00);
        cyc(40);
        chk(8'(int_cnt - n0), 8'h01);
        rd_chk(`CSW_ADDR_STAT1, 8'h02, 8'h02);
        mode <= CSW_STOP;
        cyc(400);
        chk(8'(int_cnt - n0), 8'h02);
        w0 = wk_cnt;
        mode <= CSW_SLEEP;
        cyc(400);
        chk(8'(wk_cnt - w0), 8'h01);
        chk({7'h00, rail_en}, 8'h01);
        restart();
        wr_reg(`CSW_ADDR_STAT1, 8'h02);
        $display("test cyclic wake done");
        wr_reg(`CSW_ADDR_GPCFG, {5'h00, `CSW_GP_HS_CS});
        wr_reg(`CSW_ADDR_WKSRC, 8'h01);
        wr_reg(`CSW_ADDR_TIMER, 8'h30);
        n0 = int_cnt;
        cyc(20);
        chk({7'h00, hs}, 8'h01);
        cyc(40);
        chk({7'h00, hs}, 8'h00);
        cyc(320);
        chk(8'(int_cnt - n0), 8'h00);
        sw_closed <= 1'b1;
        cyc(400);
        chk(8'(int_cnt - n0), 8'h01);
        rd_chk(`CSW_ADDR_STAT1, 8'h01, 8'h01);
        rd_chk(`CSW_ADDR_LEVEL, 8'h01, 8'h00);
        sw_closed <= 1'b0;
        cyc(400);
        chk(8'(int_cnt - n0), 8'h02);
        mode <= CSW_STOP;
        sw_closed <= 1'b1;
        cyc(800);
        chk(8'(int_cnt - n0), 8'h02);
        $display("test cyclic sense done");
        mode <= CSW_NORMAL;
        hs_oc <= 1'b1;
        cyc(2);
        h0 = hs_cnt;
        cyc(800);
        chk(8'(hs_cnt - h0), 8'h00);
        rd_chk(`CSW_ADDR_STAT2, 8'h01, 8'h01);
        rd_chk(`CSW_ADDR_LEVEL, 8'h02, 8'h02);
        hs_oc <= 1'b0;
        wr_reg(`CSW_ADDR_GPCFG, {5'h00, `CSW_GP_HS_CS});
        tsd <= 1'b1;
        cyc(2);
        h0 = hs_cnt;
        cyc(800);
        chk(8'(hs_cnt - h0), 8'h00);
        rd_chk(`CSW_ADDR_STAT2, 8'h02, 8'h02);
        tsd <= 1'b0;
        wr_reg(`CSW_ADDR_GPCFG, {5'h00, `CSW_GP_HS_CS});
        mode <= CSW_FAILSAFE;
        cyc(2);
        h0 = hs_cnt;
        cyc(800);
        chk(8'(hs_cnt - h0), 8'h00);
        wr_reg(`CSW_ADDR_STAT1, 8'h01);
        sw_closed <= 1'b0;
        cyc(3);
        rd_chk(`CSW_ADDR_STAT1, 8'h01, 8'h01);
        sw_closed <= 1'b1;
        cyc(3);
        $display("test faults done");
        mode <= CSW_SLEEP;
        cyc(2);
        w0 = wk_cnt;
        r0 = rl_cnt;
        sleep_cmd <= 1'b1;
        @(posedge clk);
        sleep_cmd <= 1'b0;
        cyc(5);
        chk(8'(wk_cnt - w0), 8'h01);
        chk({7'h00, rl_cnt != r0}, 8'h01);
        w0 = wk_cnt;
        hs_oc <= 1'b1;
        cyc(4);
        chk(8'(wk_cnt - w0), 8'h01);
        $display("test sleep with flags done");
        give_verdict();
    end

endmodule : tb
`default_nettype wire
